// ===== core/acl_pkg.sv
`default_nettype none
package acl_pkg;
   localparam int AXI_AW = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BANK = 8'h04;
   localparam logic [7:0] OFS_INDEX = 8'h08;
   localparam logic [7:0] OFS_ACCUM = 8'h0C;
   localparam logic [7:0] OFS_FLAGS = 8'h10;
   localparam logic [7:0] OFS_INSTR = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_MADDR = 8'h1C;
   localparam logic [7:0] OFS_MDATA = 8'h20;
   localparam int CTRL_EXT_BIT = 0;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_BAD_BIT = 1;
   localparam int FLG_C = 0;
   localparam int FLG_DIGIT_CARRY = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OVERFLOW = 3;
   localparam int FLG_N = 4;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   localparam logic [5:0] OPC_ADD_CARRY = 6'h08;
   localparam logic [7:0] OPC_AND_LIT = 8'h0B;
   localparam logic [7:0] INDEX_LIMIT = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [7:0] RST_ACCUM = 8'h00;
   localparam logic [4:0] RST_FLAGS = 5'h00;
   localparam logic [3:0] RST_BANK = 4'h0;
   localparam logic [11:0] RST_INDEX = 12'h000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_EXEC = 2'b10
   } acl_state_type;
endpackage
`default_nettype wire

// ===== core/acl_dmem.sv
`timescale 1ns/10ps
`default_nettype none
module acl_dmem #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [AW-1:0] addr,
   input wire logic wr_en,
   input wire logic [DW-1:0] wr_data,
   output logic [DW-1:0] rd_data_r
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= mem[addr];
      end
   end
endmodule
`default_nettype wire

// ===== core/acl_core.sv
`timescale 1ns/10ps
`default_nettype none
module acl_core import acl_pkg::*; #(
   parameter int MEM_AW = 12
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction
   function automatic logic is_add(input logic [15:0] ins);
      return ins[15:10] == OPC_ADD_CARRY;
   endfunction
   function automatic logic is_andl(input logic [15:0] ins);
      return ins[15:8] == OPC_AND_LIT;
   endfunction

   logic aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r, wdata_r;
   logic [3:0] wstrb_r;
   logic [7:0] awaddr_r;
   logic ext_en_r, bad_r;
   logic [3:0] bank_r;
   logic [11:0] index_r, maddr_r;
   logic [7:0] accum_r, accum_nxt;
   logic [4:0] flags_r, flags_nxt;
   logic [15:0] instr_r;
   acl_state_type state_r, state_nxt;
   logic [7:0] mem_rd;

   // write channel capture, either order
   wire aw_hs = s_axi_awvalid & awready_r;
   wire w_hs = s_axi_wvalid & wready_r;
   wire aw_have = aw_got_r | aw_hs;
   wire w_have = w_got_r | w_hs;
   wire wr_fire = aw_have & w_have & ~bvalid_r;
   wire aw_got_nxt = aw_have & ~wr_fire;
   wire w_got_nxt = w_have & ~wr_fire;
   wire [7:0] wr_addr = aw_got_r ? awaddr_r : s_axi_awaddr;
   wire [31:0] wr_data = w_got_r ? wdata_r : s_axi_wdata;
   wire [3:0] wr_strb = w_got_r ? wstrb_r : s_axi_wstrb;
   wire busy = state_r != ST_IDLE;
   wire wr_ctrl = wr_fire & (wr_addr == OFS_CTRL);
   wire wr_bank = wr_fire & (wr_addr == OFS_BANK);
   wire wr_index = wr_fire & (wr_addr == OFS_INDEX);
   wire wr_accum = wr_fire & (wr_addr == OFS_ACCUM) & ~busy;
   wire wr_flags = wr_fire & (wr_addr == OFS_FLAGS) & ~busy;
   wire wr_instr = wr_fire & (wr_addr == OFS_INSTR) & ~busy;
   wire wr_stat = wr_fire & (wr_addr == OFS_STAT);
   wire wr_maddr = wr_fire & (wr_addr == OFS_MADDR);
   wire wr_mdata = wr_fire & (wr_addr == OFS_MDATA) & ~busy;
   wire wr_hit = (wr_addr == OFS_CTRL) | (wr_addr == OFS_BANK) | (wr_addr == OFS_INDEX) |
                 (wr_addr == OFS_ACCUM) | (wr_addr == OFS_FLAGS) | (wr_addr == OFS_INSTR) |
                 (wr_addr == OFS_STAT) | (wr_addr == OFS_MADDR) | (wr_addr == OFS_MDATA);
   wire [31:0] wr_merged = merge(32'h0000_0000, wr_data, wr_strb);
   wire [31:0] instr_merged = merge({16'h0000, instr_r}, wr_data, wr_strb);
   wire [15:0] new_instr = instr_merged[15:0];
   wire new_legal = is_add(new_instr) | is_andl(new_instr);

   // read channel
   wire ar_hs = s_axi_arvalid & arready_r;
   wire rvalid_nxt = ar_hs | (rvalid_r & ~s_axi_rready);
   logic [31:0] rd_mux;
   logic rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         OFS_CTRL: rd_mux = {31'h0, ext_en_r};
         OFS_BANK: rd_mux = {28'h0, bank_r};
         OFS_INDEX: rd_mux = {20'h0, index_r};
         OFS_ACCUM: rd_mux = {24'h0, accum_r};
         OFS_FLAGS: rd_mux = {27'h0, flags_r};
         OFS_INSTR: rd_mux = {16'h0, instr_r};
         OFS_STAT: rd_mux = {30'h0, bad_r, busy};
         OFS_MADDR: rd_mux = {20'h0, maddr_r};
         OFS_MDATA: rd_mux = {24'h0, mem_rd};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // operand address resolution
   wire [7:0] f_addr = instr_r[7:0];
   wire bank_bit = instr_r[BANK_BIT];
   wire dest_bit = instr_r[DEST_BIT];
   wire use_index = ~bank_bit & ext_en_r & (f_addr <= INDEX_LIMIT);
   wire [11:0] idx_addr = index_r + {4'h0, f_addr};
   wire [11:0] acc_addr = (f_addr < ACCESS_SPLIT) ? {4'h0, f_addr} :
                          {ACCESS_HI_BANK, f_addr};
   wire [11:0] bnk_addr = {bank_r, f_addr};
   wire [11:0] eff_addr = bank_bit ? bnk_addr : (use_index ? idx_addr : acc_addr);
   wire [MEM_AW-1:0] mem_addr = busy ? eff_addr[MEM_AW-1:0] : maddr_r[MEM_AW-1:0];

   // alu
   wire in_exec = state_r == ST_EXEC;
   wire [8:0] add_full = {1'b0, accum_r} + {1'b0, mem_rd} + {8'h00, flags_r[FLG_C]};
   wire [4:0] add_lo = {1'b0, accum_r[3:0]} + {1'b0, mem_rd[3:0]} + {4'h0, flags_r[FLG_C]};
   wire [7:0] add_res = add_full[7:0];
   wire add_ovf = (accum_r[7] == mem_rd[7]) & (add_res[7] != accum_r[7]);
   wire [7:0] and_res = accum_r & instr_r[7:0];
   wire exec_add = in_exec & is_add(instr_r);
   wire exec_and = in_exec & is_andl(instr_r);
   wire mem_we = (exec_add & dest_bit) | (wr_mdata & ~busy);
   wire [7:0] mem_wd = busy ? add_res : wr_merged[7:0];

   always_comb begin
      accum_nxt = accum_r;
      flags_nxt = flags_r;
      if (exec_add) begin
         if (!dest_bit) accum_nxt = add_res;
         flags_nxt[FLG_C] = add_full[8];
         flags_nxt[FLG_DIGIT_CARRY] = add_lo[4];
         flags_nxt[FLG_OVERFLOW] = add_ovf;
         flags_nxt[FLG_Z] = add_res == 8'h00;
         flags_nxt[FLG_N] = add_res[7];
      end else if (exec_and) begin
         accum_nxt = and_res;
         flags_nxt[FLG_Z] = and_res == 8'h00;
         flags_nxt[FLG_N] = and_res[7];
      end else begin
         if (wr_accum) accum_nxt = wr_merged[7:0];
         if (wr_flags) flags_nxt = wr_merged[4:0];
      end
   end

   always_comb begin
      case (state_r)
         ST_IDLE: state_nxt = (wr_instr & new_legal) ? ST_READ : ST_IDLE;
         ST_READ: state_nxt = ST_EXEC;
         ST_EXEC: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   acl_dmem #(.AW(MEM_AW), .DW(8)) u_dmem (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .addr(mem_addr),
      .wr_en(mem_we),
      .wr_data(mem_wd),
      .rd_data_r(mem_rd)
   );

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         awready_r <= ~aw_got_nxt;
         wready_r <= ~w_got_nxt;
         if (aw_hs) awaddr_r <= s_axi_awaddr;
         if (w_hs) wdata_r <= s_axi_wdata;
         if (w_hs) wstrb_r <= s_axi_wstrb;
         if (wr_fire) bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         bvalid_r <= wr_fire | (bvalid_r & ~s_axi_bready);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RESP_OKAY;
      end else begin
         arready_r <= ~rvalid_nxt;
         rvalid_r <= rvalid_nxt;
         if (ar_hs) rdata_r <= rd_mux;
         if (ar_hs) rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_en_r <= 1'b0;
         bank_r <= RST_BANK;
         index_r <= RST_INDEX;
         maddr_r <= 12'h000;
         instr_r <= 16'h0000;
         bad_r <= 1'b0;
         accum_r <= RST_ACCUM;
         flags_r <= RST_FLAGS;
         state_r <= ST_IDLE;
      end else begin
         if (wr_ctrl) ext_en_r <= wr_merged[CTRL_EXT_BIT];
         if (wr_bank) bank_r <= wr_merged[3:0];
         if (wr_index) index_r <= wr_merged[11:0];
         if (wr_maddr) maddr_r <= wr_merged[11:0];
         if (wr_instr) instr_r <= new_instr;
         // set wins over write-one-to-clear
         bad_r <= (wr_instr & ~new_legal) | (bad_r & ~(wr_stat & wr_merged[STAT_BAD_BIT]));
         accum_r <= accum_nxt;
         flags_r <= flags_nxt;
         state_r <= state_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   AST_ADD_SUM: assert property (exec_add & ~dest_bit |=> accum_r == $past(add_res))
      else $error("add result not in accumulator");
   AST_ADD_ACC_KEEPS_MEM: assert property (exec_add & ~dest_bit |-> !mem_we)
      else $error("memory written with destination accumulator");
   AST_ADD_TO_MEM: assert property (exec_add & dest_bit |-> mem_we && mem_wd == add_res
      ##1 accum_r == $past(accum_r)) else $error("add result not written back");
   AST_ACCESS_ADDR: assert property (busy & ~bank_bit & ~use_index |->
      eff_addr[7:0] == f_addr && eff_addr[11:8] == (f_addr[7] ? ACCESS_HI_BANK : 4'h0))
      else $error("access bank address wrong");
   AST_BANKED_ADDR: assert property (busy & bank_bit |-> eff_addr == {bank_r, f_addr})
      else $error("banked address wrong");
   AST_INDEXED_ADDR: assert property (busy & ~bank_bit & ext_en_r &
      (f_addr <= INDEX_LIMIT) |-> eff_addr == index_r + {4'h0, f_addr})
      else $error("indexed address wrong");
   AST_AND_LIT: assert property (exec_and |=>
      accum_r == ($past(accum_r) & $past(instr_r[7:0])) &&
      flags_r[FLG_C] == $past(flags_r[FLG_C])) else $error("and literal result wrong");
   AST_TWO_CLOCKS: assert property (state_r == ST_IDLE ##1 state_r == ST_READ |->
      ##1 state_r == ST_EXEC ##1 state_r == ST_IDLE) else $error("instruction cycle length wrong");
   AST_ADD_FLAGS: assert property (exec_add |=>
      flags_r[FLG_Z] == ($past(add_res) == 8'h00))
      else $error("zero flag wrong after add");
endmodule
`default_nettype wire

// ===== bench/acl_axi_bfm.sv
`timescale 1ns/10ps
`default_nettype none
module acl_axi_bfm import acl_pkg::*; (
   input wire logic core_clk,
   output logic [AXI_AW-1:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [AXI_AW-1:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   int tmo = 0;
   logic [1:0] rresp_seen = 2'h0;
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end
   // write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
      int i;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      resp = 2'h3;
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awvalid <= 1'b0;
            s_axi_awaddr <= ~a;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wvalid <= 1'b0;
            s_axi_wdata <= ~d;
         end
         if (s_axi_bvalid) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
      if (i == 40) tmo++;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int i;
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      d = 'x;
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arvalid <= 1'b0;
            s_axi_araddr <= ~a;
         end
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            rresp_seen = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      if (i == 40) tmo++;
   endtask
endmodule
`default_nettype wire

// ===== bench/add_carry_and_literal_and_alu_test.sv
`timescale 1ns/10ps
`default_nettype none
module add_carry_and_literal_and_alu_test import acl_pkg::*;;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int fails = 0;
   int cmp_count = 0;
   always #50 core_clk = ~core_clk;
   acl_core #(.MEM_AW(12)) dut (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );
   acl_axi_bfm bfm (
      .core_clk(core_clk),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      bfm.wr(a, d, r);
      if (bfm.tmo != 0) test_done;
      chk({30'h0, r}, {30'h0, RESP_OKAY});
   endtask
   task automatic get(input logic [7:0] a, output logic [31:0] d);
      bfm.rd(a, d);
      if (bfm.tmo != 0) test_done;
   endtask
   task automatic idle_wait;
      logic [31:0] v;
      int i;
      for (i = 0; i < 20; i++) begin
         get(OFS_STAT, v);
         if (v[STAT_BUSY_BIT] === 1'b0) break;
      end
      if (i == 20) begin
         fails++;
         test_done;
      end
   endtask
   task automatic run_add(input logic ext, input logic [3:0] bnk, input logic [11:0] idx,
         input logic a, input logic dd, input logic [7:0] f, input logic [7:0] w,
         input logic c, input logic [7:0] m);
      logic [11:0] pa;
      logic [8:0] s;
      logic [4:0] fl;
      logic [31:0] v;
      pa = {bnk, f};
      if (!a) pa = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HI_BANK, f};
      if (!a && ext && f <= INDEX_LIMIT) pa = idx + {4'h0, f};
      s = w + m + c;
      fl[FLG_C] = s[8];
      fl[FLG_DIGIT_CARRY] = (w[3:0] + m[3:0] + c) > 15;
      fl[FLG_Z] = (s[7:0] == 8'h00);
      fl[FLG_OVERFLOW] = (w[7] == m[7]) && (s[7] != w[7]);
      fl[FLG_N] = s[7];
      put(OFS_CTRL, {31'h0, ext});
      put(OFS_BANK, {28'h0, bnk});
      put(OFS_INDEX, {20'h0, idx});
      put(OFS_MADDR, {20'h0, pa});
      put(OFS_MDATA, {24'h0, m});
      put(OFS_ACCUM, {24'h0, w});
      put(OFS_FLAGS, {27'h0, ~fl[4:1], c});
      put(OFS_INSTR, {16'h0, OPC_ADD_CARRY, dd, a, f});
      idle_wait;
      get(OFS_ACCUM, v);
      chk(v, {24'h0, dd ? w : s[7:0]});
      get(OFS_MDATA, v);
      chk(v, {24'h0, dd ? s[7:0] : m});
      get(OFS_FLAGS, v);
      chk(v, {27'h0, fl});
   endtask
   task automatic and_lit(input logic [7:0] w, input logic [7:0] k, input logic [4:0] fin);
      logic [4:0] fl;
      logic [31:0] v;
      fl = fin;
      fl[FLG_N] = w[7] & k[7];
      fl[FLG_Z] = ((w & k) == 8'h00);
      put(OFS_ACCUM, {24'h0, w});
      put(OFS_FLAGS, {27'h0, fin});
      put(OFS_INSTR, {16'h0, OPC_AND_LIT, k});
      idle_wait;
      get(OFS_ACCUM, v);
      chk(v, {24'h0, w & k});
      get(OFS_FLAGS, v);
      chk(v, {27'h0, fl});
   endtask
   task automatic bad_opcode;
      logic [31:0] v;
      put(OFS_ACCUM, 32'h0000_005A);
      put(OFS_INSTR, 32'h0000_FFFF);
      get(OFS_STAT, v);
      chk(v, 32'h0000_0002);
      get(OFS_ACCUM, v);
      chk(v, 32'h0000_005A);
      put(OFS_STAT, 32'h0000_0002);
      get(OFS_STAT, v);
      chk(v, 32'h0000_0000);
   endtask
   task automatic bad_access;
      logic [1:0] r;
      logic [31:0] v;
      bfm.wr(8'h3C, 32'h0000_0000, r);
      if (bfm.tmo != 0) test_done;
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      get(8'h3C, v);
      chk({30'h0, bfm.rresp_seen}, {30'h0, RESP_SLVERR});
      chk(v, 32'h0000_0000);
      get(OFS_ACCUM, v);
      chk({30'h0, bfm.rresp_seen}, {30'h0, RESP_OKAY});
   endtask
   task automatic test_done;
      fails += bfm.tmo;
      $display("mismatches %0d compares %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      run_add(0, 4'h3, 12'h000, 1, 0, 8'h45, 8'h4D, 1, 8'h02);
      run_add(0, 4'h3, 12'h000, 0, 0, 8'h10, 8'h7F, 1, 8'h00);
      run_add(0, 4'h3, 12'h000, 0, 1, 8'h90, 8'hFF, 1, 8'h00);
      run_add(1, 4'h3, 12'h200, 0, 0, 8'h5F, 8'h08, 0, 8'h08);
      run_add(1, 4'h3, 12'h200, 0, 1, 8'h60, 8'h80, 0, 8'h80);
      run_add(1, 4'h5, 12'h200, 1, 0, 8'h20, 8'h0F, 1, 8'h70);
      and_lit(8'hA3, 8'h5F, 5'h1F);
      and_lit(8'h5A, 8'hA5, 5'h00);
      and_lit(8'h80, 8'hFF, 5'h0A);
      bad_opcode;
      bad_access;
      test_done;
   end
endmodule
`default_nettype wire
